// File: common/dss_pkg.sv
// Package of constants for the alignment source selection block
// Summary of operation
// RULE_01: Offset bank sources: bits 15..12, any combination
// RULE_02: Correction bank sources: bits 7..4, same enables
// RULE_03: Mixer bank sources: bits 15..12 next register
// RULE_04: Oscillator accumulators reset on any enabled source
// RULE_05: Formatter single source: frame, pin, or none
// RULE_06: Software trigger is stored bit 1 level
// RULE_07: FIFO write side sources, reset 0010
// RULE_08: FIFO read side sources, reset 0100
// RULE_09: Divider select: reference or FIFO-input choice
// RULE_10: First select register resets to 0x1111
// RULE_11: Second select register resets to 0x1140
// RULE_12: Third select register resets to 0x2400
// RULE_13: Software keeps reserved bits at reset values
// RULE_14: Bank copies shadow to active in one cycle
package dss_pkg;

   ////////////////////////////////////////////////////////////////////////
   // Register port geometry
   localparam int ADDR_W = 7;              // Register address width
   localparam int DATA_W = 16;             // Register data width

   ////////////////////////////////////////////////////////////////////////
   // Register addresses
   localparam logic [6:0] ADDR_RSVD_1D   = 7'h1d;
   localparam logic [6:0] ADDR_IQ_SEL    = 7'h1e;
   localparam logic [6:0] ADDR_MIX_SEL   = 7'h1f;
   localparam logic [6:0] ADDR_BUF_SEL   = 7'h20;
   localparam logic [6:0] ADDR_RSVD_21   = 7'h21;

   ////////////////////////////////////////////////////////////////////////
   // Reset values
   localparam logic [15:0] RST_RSVD_1D   = 16'h0000;
   localparam logic [15:0] RST_IQ_SEL    = 16'h1111;
   localparam logic [15:0] RST_MIX_SEL   = 16'h1140;
   localparam logic [15:0] RST_BUF_SEL   = 16'h2400;
   localparam logic [15:0] RST_RSVD_21   = 16'h0000;

   ////////////////////////////////////////////////////////////////////////
   // Field positions (least significant bit of each field)
   localparam int OFS_SEL_LSB    = 12;     // Offset bank enables
   localparam int CORR_SEL_LSB   = 4;      // Correction bank enables
   localparam int MIX_SEL_LSB    = 12;     // Mixer bank enables
   localparam int OSC_SEL_LSB    = 4;      // Oscillator enables
   localparam int FMT_SEL_LSB    = 2;      // Formatter two-bit select
   localparam int SW_TRIG_BIT    = 1;      // Software trigger bit
   localparam int FIFO_WR_LSB    = 12;     // FIFO write side enables
   localparam int FIFO_RD_LSB    = 8;      // FIFO read side enables
   localparam int CLKDIV_BIT     = 0;      // Divider source select

   ////////////////////////////////////////////////////////////////////////
   // Bit order inside each four-bit enable field
   localparam int SRC_SW   = 3;            // Software trigger
   localparam int SRC_PIN  = 2;            // Alignment pin
   localparam int SRC_REF  = 1;            // Periodic reference strobe
   localparam int SRC_LOW  = 0;            // Auto write or framing strobe

   ////////////////////////////////////////////////////////////////////////
   // Formatter select codes
   localparam logic [1:0] FMT_FRAME = 2'h0;
   localparam logic [1:0] FMT_PIN   = 2'h1;

endpackage

// File: src/dss_source_mux.sv
// Enable-gated OR of four alignment source events
module dss_source_mux (
   // Field of per-source enables
   input  wire logic [3:0] enables,
   // Per-source event pulses, same bit order
   input  wire logic [3:0] events,
   // Combined alignment event
   output logic            hit
);

   ////////////////////////////////////////////////////////////////////////
   // Any enabled source fires the target; several may be enabled
   assign hit = |(enables & events);

endmodule

// File: src/dss_sync_select.sv
// Alignment source selection with select registers and bank loading
module dss_sync_select #(
   parameter int OFS_W  = 32,             // Offset bank width
   parameter int CORR_W = 32,             // Correction bank width
   parameter int MIX_W  = 32              // Mixer bank width
) (
   // Clock and reset
   input  wire logic                      clk,
   input  wire logic                      srst,
   // Register port
   input  wire logic                      regWrEn,
   input  wire logic                      regRdEn,
   input  wire logic [dss_pkg::ADDR_W-1:0] regAddr,
   input  wire logic [dss_pkg::DATA_W-1:0] regWrData,
   output logic      [dss_pkg::DATA_W-1:0] regRdData,
   output logic                           regRdValid,
   // Strobe pins from the host logic
   input  wire logic                      alignPin,
   input  wire logic                      refStrobe,
   input  wire logic                      frameStrobe,
   // Automatic triggers from bank register writes
   input  wire logic                      offsetWritten,
   input  wire logic                      corrWritten,
   input  wire logic                      mixerWritten,
   // Buffered bank values
   input  wire logic [OFS_W-1:0]          offsetShadow,
   input  wire logic [CORR_W-1:0]         corrShadow,
   input  wire logic [MIX_W-1:0]          mixerShadow,
   // Active bank values
   output logic      [OFS_W-1:0]          offsetActive,
   output logic      [CORR_W-1:0]         corrActive,
   output logic      [MIX_W-1:0]          mixerActive,
   // Alignment pulses to the datapath
   output logic                           oscAlign,
   output logic                           fmtAlign,
   output logic                           fifoWrAlign,
   output logic                           fifoRdAlign,
   output logic                           clkDivAlign
);

   ////////////////////////////////////////////////////////////////////////
   // Address match, used by both the write and read paths
   function automatic logic isAddr(
      input logic [dss_pkg::ADDR_W-1:0] a,
      input logic [dss_pkg::ADDR_W-1:0] b
   );
      isAddr = (a == b);
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Select registers
   logic [15:0] rsvd1dReg;                 // Reserved word, stored only
   logic [15:0] iqSelReg;                  // Offset and correction enables
   logic [15:0] mixSelReg;                 // Mixer, oscillator, formatter
   logic [15:0] bufSelReg;                 // FIFO and divider selects
   logic [15:0] rsvd21Reg;                 // Reserved word, stored only

   // Register writes; reserved bits are stored as written, software
   // is trusted to leave them at reset values
   always_ff @(posedge clk) begin
      if (srst) begin
         rsvd1dReg <= dss_pkg::RST_RSVD_1D; // RULE_13
         iqSelReg  <= dss_pkg::RST_IQ_SEL;  // RULE_10
         mixSelReg <= dss_pkg::RST_MIX_SEL; // RULE_11
         bufSelReg <= dss_pkg::RST_BUF_SEL; // RULE_12
         rsvd21Reg <= dss_pkg::RST_RSVD_21; // RULE_13
      end else if (regWrEn) begin
         // Offset and correction selects
         if (isAddr(regAddr, dss_pkg::ADDR_IQ_SEL)) begin
            iqSelReg <= regWrData;
         end
         // Mixer selects and the software trigger bit
         if (isAddr(regAddr, dss_pkg::ADDR_MIX_SEL)) begin
            mixSelReg <= regWrData;         // RULE_06
         end
         // FIFO and divider selects
         if (isAddr(regAddr, dss_pkg::ADDR_BUF_SEL)) begin
            bufSelReg <= regWrData;
         end
         // Reserved words
         if (isAddr(regAddr, dss_pkg::ADDR_RSVD_1D)) begin
            rsvd1dReg <= regWrData;
         end
         if (isAddr(regAddr, dss_pkg::ADDR_RSVD_21)) begin
            rsvd21Reg <= regWrData;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Read path: one cycle latency, unmapped addresses read zero
   always_ff @(posedge clk) begin
      if (srst) begin
         regRdData  <= 16'h0000;
         regRdValid <= 1'b0;
      end else begin
         regRdValid <= regRdEn;
         if (!regRdEn) begin
            regRdData <= regRdData;         // Hold last answer
         end else if (isAddr(regAddr, dss_pkg::ADDR_IQ_SEL)) begin
            regRdData <= iqSelReg;
         end else if (isAddr(regAddr, dss_pkg::ADDR_MIX_SEL)) begin
            regRdData <= mixSelReg;
         end else if (isAddr(regAddr, dss_pkg::ADDR_BUF_SEL)) begin
            regRdData <= bufSelReg;
         end else if (isAddr(regAddr, dss_pkg::ADDR_RSVD_1D)) begin
            regRdData <= rsvd1dReg;
         end else if (isAddr(regAddr, dss_pkg::ADDR_RSVD_21)) begin
            regRdData <= rsvd21Reg;
         end else begin
            regRdData <= 16'h0000;          // Unmapped
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Pin synchronisers: two flops, then an edge detector on the second
   logic [2:0] pinMeta;                    // First stage, read by stage two
   logic [2:0] pinSync;                    // Second stage
   logic [2:0] pinPrev;                    // Edge detector history
   logic [2:0] pinRise;                    // One-cycle rising edges

   always_ff @(posedge clk) begin
      if (srst) begin
         pinMeta <= 3'h0;
         pinSync <= 3'h0;
         pinPrev <= 3'h0;
      end else begin
         pinMeta <= {frameStrobe, refStrobe, alignPin};
         pinSync <= pinMeta;
         pinPrev <= pinSync;
      end
   end

   assign pinRise = pinSync & ~pinPrev;

   ////////////////////////////////////////////////////////////////////////
   // Software trigger: the stored bit is the level; its rise is the event,
   // so a bit left high fires once and must be cleared to fire again
   logic swPrev;                           // Previous stored bit
   logic swRise;                           // Software trigger event

   always_ff @(posedge clk) begin
      if (srst) begin
         swPrev <= 1'b0;
      end else begin
         swPrev <= mixSelReg[dss_pkg::SW_TRIG_BIT];
      end
   end

   assign swRise = mixSelReg[dss_pkg::SW_TRIG_BIT] & ~swPrev; // RULE_06

   ////////////////////////////////////////////////////////////////////////
   // Event vectors in field bit order: sw, pin, reference, low slot
   logic       pinEv;                      // Alignment pin event
   logic       refEv;                      // Reference strobe event
   logic       frameEv;                    // Framing strobe event
   logic [3:0] ofsEvents;                  // Low slot is auto write
   logic [3:0] corrEvents;
   logic [3:0] mixEvents;
   logic [3:0] frmEvents;                  // Low slot is framing strobe
   logic [3:0] divEvents;                  // Reference slot masked

   assign pinEv      = pinRise[0];
   assign refEv      = pinRise[1];
   assign frameEv    = pinRise[2];
   assign ofsEvents  = {swRise, pinEv, refEv, offsetWritten};
   assign corrEvents = {swRise, pinEv, refEv, corrWritten};
   assign mixEvents  = {swRise, pinEv, refEv, mixerWritten};
   assign frmEvents  = {swRise, pinEv, refEv, frameEv};
   assign divEvents  = {swRise, pinEv, 1'b0, frameEv};

   ////////////////////////////////////////////////////////////////////////
   // Per-target source selection
   logic ofsHit;                           // Offset bank load
   logic corrHit;                          // Correction bank load
   logic mixHit;                           // Mixer bank load
   logic oscHit;                           // Accumulator reset
   logic fifoWrHit;                        // Write pointer align
   logic fifoRdHit;                        // Read pointer align
   logic divFifoHit;                       // Divider via FIFO input field
   logic fmtHit;                           // Formatter align
   logic divHit;                           // Divider align

   dss_source_mux uOfsMux (
      .enables (iqSelReg[dss_pkg::OFS_SEL_LSB +: 4]),  // RULE_01
      .events  (ofsEvents),
      .hit     (ofsHit)
   );

   dss_source_mux uCorrMux (
      .enables (iqSelReg[dss_pkg::CORR_SEL_LSB +: 4]), // RULE_02
      .events  (corrEvents),
      .hit     (corrHit)
   );

   dss_source_mux uMixMux (
      .enables (mixSelReg[dss_pkg::MIX_SEL_LSB +: 4]), // RULE_03
      .events  (mixEvents),
      .hit     (mixHit)
   );

   dss_source_mux uOscMux (
      .enables (mixSelReg[dss_pkg::OSC_SEL_LSB +: 4]), // RULE_04
      .events  (frmEvents),
      .hit     (oscHit)
   );

   dss_source_mux uFifoWrMux (
      .enables (bufSelReg[dss_pkg::FIFO_WR_LSB +: 4]), // RULE_07
      .events  (frmEvents),
      .hit     (fifoWrHit)
   );

   dss_source_mux uFifoRdMux (
      .enables (bufSelReg[dss_pkg::FIFO_RD_LSB +: 4]), // RULE_08
      .events  (frmEvents),
      .hit     (fifoRdHit)
   );

   // Divider follows the FIFO input field, but only frame, pin and sw
   dss_source_mux uDivMux (
      .enables (bufSelReg[dss_pkg::FIFO_WR_LSB +: 4]), // RULE_09
      .events  (divEvents),
      .hit     (divFifoHit)
   );

   // Formatter takes a single source; codes two and three disable it
   always_comb begin
      case (mixSelReg[dss_pkg::FMT_SEL_LSB +: 2])
         dss_pkg::FMT_FRAME: fmtHit = frameEv; // RULE_05
         dss_pkg::FMT_PIN:   fmtHit = pinEv;   // RULE_05
         default:            fmtHit = 1'b0;    // RULE_05
      endcase
   end

   // Divider source: reference strobe, or the FIFO input choice
   assign divHit = bufSelReg[dss_pkg::CLKDIV_BIT] ? divFifoHit
                                                  : refEv; // RULE_09

   ////////////////////////////////////////////////////////////////////////
   // Double-buffered banks: whole bank copied on one edge so that all
   // fields take effect together
   always_ff @(posedge clk) begin
      if (srst) begin
         offsetActive <= '0;
      end else if (ofsHit) begin
         offsetActive <= offsetShadow;     // RULE_14
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         corrActive <= '0;
      end else if (corrHit) begin
         corrActive <= corrShadow;         // RULE_14
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         mixerActive <= '0;
      end else if (mixHit) begin
         mixerActive <= mixerShadow;       // RULE_14
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Alignment pulses, registered so the datapath sees clean one-cycle
   // strobes; costs one cycle of latency against the event
   always_ff @(posedge clk) begin
      if (srst) begin
         oscAlign    <= 1'b0;
         fmtAlign    <= 1'b0;
         fifoWrAlign <= 1'b0;
         fifoRdAlign <= 1'b0;
         clkDivAlign <= 1'b0;
      end else begin
         oscAlign    <= oscHit;            // RULE_04
         fmtAlign    <= fmtHit;            // RULE_05
         fifoWrAlign <= fifoWrHit;         // RULE_07
         fifoRdAlign <= fifoRdHit;         // RULE_08
         clkDivAlign <= divHit;            // RULE_09
      end
   end

endmodule

// File: test/dss_sync_select_sva.sv
// Checker of register port and alignment behaviour at the block ports
module dss_sync_select_sva #(
   parameter int OFS_W = 32,                // Offset bank width
   parameter int MIX_W = 32                 // Mixer bank width
) (
   // Clock and reset
   input wire logic                       clk,
   input wire logic                       srst,
   // Register port
   input wire logic                       regWrEn,
   input wire logic                       regRdEn,
   input wire logic [dss_pkg::ADDR_W-1:0] regAddr,
   input wire logic [dss_pkg::DATA_W-1:0] regWrData,
   input wire logic [dss_pkg::DATA_W-1:0] regRdData,
   input wire logic                       regRdValid,
   // Banks
   input wire logic                       offsetWritten,
   input wire logic [OFS_W-1:0]           offsetShadow,
   input wire logic [OFS_W-1:0]           offsetActive,
   input wire logic                       mixerWritten,
   input wire logic [MIX_W-1:0]           mixerShadow,
   input wire logic [MIX_W-1:0]           mixerActive,
   // Alignment pulses
   input wire logic                       oscAlign,
   input wire logic                       fmtAlign,
   input wire logic                       fifoWrAlign,
   input wire logic                       fifoRdAlign,
   input wire logic                       clkDivAlign
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge clk); endclocking
   default disable iff (srst);
   logic [15:0] iqMir;                      // Mirror of offset/corr select
   logic [15:0] mixMir;                     // Mirror of mixer/osc select
   logic [15:0] bufMir;                     // Mirror of FIFO/divider select
   ////////////////////////////////////////////////////////////////////////
   // Mirrors track writes so that relations can name the live fields
   always_ff @(posedge clk) begin
      if (srst) begin
         iqMir  <= 16'h1111;
         mixMir <= 16'h1140;
         bufMir <= 16'h2400;
      end else if (regWrEn) begin
         if (regAddr == dss_pkg::ADDR_IQ_SEL) iqMir <= regWrData;
         if (regAddr == dss_pkg::ADDR_MIX_SEL) mixMir <= regWrData;
         if (regAddr == dss_pkg::ADDR_BUF_SEL) bufMir <= regWrData;
      end
   end
   ////////////////////////////////////////////////////////////////////////
   a_rd_valid_pulse: assert property (regRdEn |=> regRdValid)
      else $error("read not answered");
   a_no_idle_valid: assert property (!regRdEn |=> !regRdValid)
      else $error("valid without read");
   a_unmapped_zero: assert property (regRdEn && (regAddr < 7'h1d
      || regAddr > 7'h21) |=> regRdData == 16'h0000)
      else $error("unmapped read not zero");
   a_mix_readback: assert property (regRdEn && !regWrEn &&
      regAddr == dss_pkg::ADDR_MIX_SEL |=> regRdData == $past(mixMir))
      else $error("mixer select readback wrong");
   a_ofs_auto_load: assert property (offsetWritten && iqMir[12]
      |=> offsetActive == $past(offsetShadow))
      else $error("offset bank not loaded");
   a_mix_auto_load: assert property (mixerWritten && mixMir[12]
      |=> mixerActive == $past(mixerShadow))
      else $error("mixer bank not loaded");
   a_ofs_no_load: assert property (!$past(offsetWritten) &&
      $past(iqMir[15:12]) == 4'b0001 |-> $stable(offsetActive))
      else $error("offset bank loaded without source");
   a_fmt_none: assert property (mixMir[3] && $past(mixMir[3]) &&
      $past(mixMir[3], 2) |-> !fmtAlign)
      else $error("formatter aligned while disabled");
   a_div_tracks_ref: assert property ($past(bufMir) == 16'h2400 &&
      $past(bufMir, 2) == 16'h2400 |-> clkDivAlign == fifoWrAlign)
      else $error("divider and FIFO write differ on reference");
   a_osc_rd_pin: assert property ($past(mixMir[7:4]) == 4'b0100 &&
      $past(bufMir[11:8]) == 4'b0100 |-> oscAlign == fifoRdAlign)
      else $error("oscillator and FIFO read differ on pin");
endmodule
bind dss_sync_select dss_sync_select_sva #(.OFS_W(OFS_W), .MIX_W(MIX_W))
   chk (.clk(clk), .srst(srst), .regWrEn(regWrEn), .regRdEn(regRdEn),
   .regAddr(regAddr), .regWrData(regWrData), .regRdData(regRdData),
   .regRdValid(regRdValid), .offsetWritten(offsetWritten),
   .offsetShadow(offsetShadow), .offsetActive(offsetActive),
   .mixerWritten(mixerWritten), .mixerShadow(mixerShadow),
   .mixerActive(mixerActive), .oscAlign(oscAlign), .fmtAlign(fmtAlign),
   .fifoWrAlign(fifoWrAlign), .fifoRdAlign(fifoRdAlign),
   .clkDivAlign(clkDivAlign));

// File: test/dss_host_model.sv
// Host logic model that drives the alignment and framing strobe pins
module dss_host_model (
   // Clock and reset
   input  wire logic       clk,
   input  wire logic       srst,
   // One request bit per pin: 0 align, 1 reference, 2 frame
   input  wire logic [2:0] go,
   // Strobe pins
   output logic            alignPin,
   output logic            refStrobe,
   output logic            frameStrobe
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [3:0] hold [3] = '{default: 4'h0}; // High cycles left per pin
   ////////////////////////////////////////////////////////////////////////
   // Four high cycles per request, well above what the synchroniser needs
   always_ff @(posedge clk) begin
      for (int i = 0; i < 3; i++) begin
         hold[i] <= srst ? 4'h0 : (go[i] ? 4'hf : hold[i] >> 1);
      end
   end
   assign alignPin    = hold[0][0];
   assign refStrobe   = hold[1][0];
   assign frameStrobe = hold[2][0];
endmodule

// File: test/dss_sync_select_tb_top.sv
// Self-checking bench for the alignment source selection block
module dss_sync_select_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk = 1'b0;             // Sample clock
   logic        srst = 1'b1;            // Synchronous reset
   logic        regWrEn = 1'b0;         // Write strobe
   logic        regRdEn = 1'b0;         // Read strobe
   logic [6:0]  regAddr = 7'h00;        // Register address
   logic [15:0] regWrData = 16'h0000;   // Write data
   logic [15:0] regRdData;              // Read data
   logic        regRdValid, alignPin, refStrobe, frameStrobe;
   logic [2:0]  go = 3'h0;              // Requests to the host model
   logic [2:0]  wrPulse = 3'h0;         // Auto triggers: offset, corr, mix
   logic [31:0] shadow [3] = '{default: 32'h0000_0000};
   wire  [31:0] active [3];             // Active bank values
   wire  [4:0]  pulses;                 // osc, fmt, fifoWr, fifoRd, clkDiv
   int          num_errors = 0;
   int          checks = 0;
   always #10 clk = ~clk;
   dss_sync_select dut (.clk(clk), .srst(srst), .regWrEn(regWrEn),
      .regRdEn(regRdEn), .regAddr(regAddr), .regWrData(regWrData),
      .regRdData(regRdData), .regRdValid(regRdValid), .alignPin(alignPin),
      .refStrobe(refStrobe), .frameStrobe(frameStrobe),
      .offsetWritten(wrPulse[0]), .corrWritten(wrPulse[1]),
      .mixerWritten(wrPulse[2]), .offsetShadow(shadow[0]),
      .corrShadow(shadow[1]), .mixerShadow(shadow[2]),
      .offsetActive(active[0]), .corrActive(active[1]),
      .mixerActive(active[2]), .oscAlign(pulses[4]), .fmtAlign(pulses[3]),
      .fifoWrAlign(pulses[2]), .fifoRdAlign(pulses[1]),
      .clkDivAlign(pulses[0]));
   dss_host_model host (.clk(clk), .srst(srst), .go(go),
      .alignPin(alignPin), .refStrobe(refStrobe), .frameStrobe(frameStrobe));
   ////////////////////////////////////////////////////////////////////////
   // Shared helpers
   task automatic check(input string name, input logic [31:0] seen,
                        input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("[FAIL] %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic wr(input logic [6:0] a, input logic [15:0] d);
      @(posedge clk);
      regWrEn   <= 1'b1;
      regAddr   <= a;
      regWrData <= d;
      @(posedge clk);
      regWrEn <= 1'b0;
   endtask
   task automatic rd(input logic [6:0] a, input logic [15:0] exp);
      @(posedge clk);
      regRdEn <= 1'b1;
      regAddr <= a;
      @(posedge clk);
      regRdEn <= 1'b0;
      #1;
      check("regRdValid", regRdValid, 1'b1);
      check("regRdData", regRdData, exp);
   endtask
   // Collects every pulse over a window longer than the sync latency
   task automatic watch(input logic [4:0] exp);
      logic [4:0] seen;
      seen = 5'h00;
      repeat (10) begin
         @(posedge clk);
         #1 seen = seen | pulses;
      end
      check("pulses", seen, exp);
   endtask
   task automatic fire(input logic [2:0] m, input logic [4:0] exp);
      @(posedge clk);
      go <= m;
      @(posedge clk);
      go <= 3'h0;
      watch(exp);
   endtask
   ////////////////////////////////////////////////////////////////////////
   // Scenarios
   task automatic s_reset();
      rd(dss_pkg::ADDR_RSVD_1D, 16'h0000);
      rd(dss_pkg::ADDR_IQ_SEL, 16'h1111);
      rd(dss_pkg::ADDR_MIX_SEL, 16'h1140);
      rd(dss_pkg::ADDR_BUF_SEL, 16'h2400);
      rd(dss_pkg::ADDR_RSVD_21, 16'h0000);
      rd(7'h22, 16'h0000);
   endtask
   // Each bank loads from its own write trigger in the same cycle
   task automatic s_auto();
      for (int b = 0; b < 3; b++) begin
         @(posedge clk);
         shadow[b]  <= 32'hA5A5_0000 + b;
         wrPulse[b] <= 1'b1;
         @(posedge clk);
         wrPulse[b] <= 1'b0;
         #1;
         check("active", active[b], 32'hA5A5_0000 + b);
      end
   endtask
   task automatic s_pins();
      // New shadow values, so a load from a disabled source would show
      @(posedge clk);
      shadow[0] <= 32'h0F0F_0F0F;
      shadow[1] <= 32'hF0F0_F0F0;
      shadow[2] <= 32'h3C3C_3C3C;
      fire(3'b001, 5'b10010);
      check("offsetActive", active[0], 32'hA5A5_0000);
      check("corrActive", active[1], 32'hA5A5_0001);
      fire(3'b010, 5'b00101);
      fire(3'b100, 5'b01000);
      check("mixerActive", active[2], 32'hA5A5_0002);
   endtask
   // Formatter codes 01, 10 and 11; reserved nibble kept at reset value
   task automatic s_fmt();
      for (int c = 1; c < 4; c++) begin
         wr(dss_pkg::ADDR_MIX_SEL, 16'h1140 | 16'(c << 2));
         fire(3'b100, 5'b00000);
         fire(3'b001, (c == 1) ? 5'b11010 : 5'b10010);
      end
      wr(dss_pkg::ADDR_MIX_SEL, 16'h1140);
   endtask
   task automatic s_iq();
      wr(dss_pkg::ADDR_IQ_SEL, 16'h5151);
      shadow[0] <= 32'h1234_5678;
      shadow[1] <= 32'h8765_4321;
      fire(3'b001, 5'b10010);
      check("offsetActive", active[0], 32'h1234_5678);
      check("corrActive", active[1], 32'h8765_4321);
      rd(dss_pkg::ADDR_IQ_SEL, 16'h5151);
   endtask
   task automatic s_div();
      wr(dss_pkg::ADDR_BUF_SEL, 16'h1401);
      fire(3'b100, 5'b01101);
      fire(3'b010, 5'b00000);
   endtask
   // Software bit rises once, then is withdrawn without a second event
   task automatic s_sw();
      wr(dss_pkg::ADDR_BUF_SEL, 16'h8401);
      shadow[2] <= 32'h5A5A_1234;
      wr(dss_pkg::ADDR_MIX_SEL, 16'h9142);
      watch(5'b00101);
      check("mixerActive", active[2], 32'h5A5A_1234);
      wr(dss_pkg::ADDR_MIX_SEL, 16'h9140);
      watch(5'b00000);
      rd(dss_pkg::ADDR_MIX_SEL, 16'h9140);
   endtask
   task automatic finish_test();
      $display("checks %0d num_errors %0d", checks, num_errors);
      if (num_errors == 0 && checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   // Main sequence after eight reset cycles
   initial begin
      repeat (8) @(posedge clk);
      srst <= 1'b0;
      s_reset();
      s_auto();
      s_pins();
      s_fmt();
      s_iq();
      s_div();
      s_sw();
      finish_test();
   end
   // Watchdog far beyond the roughly two hundred cycles the run needs
   initial begin
      #500_000;
      num_errors++;
      finish_test();
   end
endmodule
